//--- bench/ovtt_adc_model.sv
`timescale 1ns/10ps
`include "ovtt_consts.svh"

module ovtt_adc_model (
  // Clock.
  input wire logic aclk,
  // Levels asked for by the bench.
  input wire logic [`OVTT_READING_W-1:0] level_one,
  input wire logic [`OVTT_READING_W-1:0] level_two,
  // Converted readings.
  output logic [`OVTT_READING_W-1:0] reading_one,
  output logic [`OVTT_READING_W-1:0] reading_two
);
  always_ff @(posedge aclk) begin
    reading_one <= level_one;
    reading_two <= level_two;
  end
endmodule

//--- bench/ovtt_top_chk.sv
`timescale 1ns/10ps
`include "ovtt_consts.svh"

module ovtt_top_chk
  import ovtt_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = `OVTT_DEBOUNCE_CYCLES
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [`OVTT_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [`OVTT_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // Sensor and fault.
  input wire logic [`OVTT_READING_W-1:0] temp_sense_channel_one,
  input wire logic overtemp_one_fault_flag
);
  logic [7:0] thr;
  logic [`OVTT_READING_W-1:0] s1;
  logic h;
  logic [31:0] cnt;
  logic fl;

  assign fl = overtemp_one_fault_flag;

  // Shadow of the threshold compare and its debounce count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr <= 8'h00;
      s1 <= '0;
      h <= 1'b0;
      cnt <= '0;
    end else begin
      if (awvalid && awready && wvalid && wready && wstrb[0] &&
          awaddr[17:2] == `OVTT_THRESH_IDX) begin
        thr <= wdata[7:0];
      end
      s1 <= temp_sense_channel_one;
      h <= {1'b0, thr} > s1[11:3];
      if (!h) begin
        cnt <= '0;
      end else if (cnt < DEBOUNCE_CYCLES) begin
        cnt <= cnt + 32'h0000_0001;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence ar_take;
    arvalid && arready;
  endsequence

  b_answer_a: assert property (wr_take |=> bvalid)
    else $error("write not answered");
  r_answer_a: assert property (ar_take |=> rvalid)
    else $error("read not answered");
  b_stand_a: assert property (bvalid && !bready |=> $stable(bvalid))
    else $error("bvalid dropped early");
  r_stand_a: assert property (rvalid && !rready |=> rvalid)
    else $error("rvalid dropped early");
  b_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while busy");
  flag_early_a: assert property (fl |-> cnt == DEBOUNCE_CYCLES)
    else $error("fault flag raised early");
  flag_late_a: assert property (cnt == DEBOUNCE_CYCLES |-> fl)
    else $error("fault flag missing");
  flag_drop_a: assert property (!h |=> !fl)
    else $error("fault flag held after drop");
endmodule

//--- bench/testbench.sv
`timescale 1ns/10ps
`include "ovtt_consts.svh"

module testbench
  import ovtt_pkg::*;
;
  localparam int unsigned DEB = 20;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = '0;
  logic [2:0] awprot = '0, arprot = '0;
  logic awready, wready, bvalid, arready, rvalid, flag;
  logic [1:0] bresp, rresp, r;
  logic [11:0] ch1_set = '0, ch2_set = '0, ch1, ch2, trimmed;
  logic [7:0] thr, tr;
  int n_errors = 0, n_checks = 0, i;

  always #2 aclk = ~aclk;

  ovtt_adc_model ovtt_adc_model_inst (.aclk(aclk), .level_one(ch1_set),
    .level_two(ch2_set), .reading_one(ch1), .reading_two(ch2));

  ovtt_top #(.DEBOUNCE_CYCLES(DEB)) ovtt_top_inst (.aclk, .aresetn,
    .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot, .rvalid, .rready, .rdata, .rresp,
    .temp_sense_channel_one(ch1), .temp_sense_channel_two(ch2),
    .temp_sense_two_trimmed(trimmed), .overtemp_one_fault_flag(flag));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic logic [11:0] exp_trim(input logic [11:0] raw,
                                           input logic [7:0] t);
    int p, v;
    p = (int'(raw) * int'(t[6:0])) >>> 10;
    v = t[7] ? int'(raw) - p : int'(raw) + p;
    return (v > 4095) ? 12'hfff : 12'(v);
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t resp %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] v,
                    input logic [3:0] s, output logic [1:0] rs);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    bready <= 1'($urandom);
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'($urandom);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(7));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(ba(`OVTT_TRIM_IDX), d, r);
    chk_word(d, 32'h0000_0000);
    rd(18'h0_0010, d, r);
    chk_resp(r, `OVTT_RESP_SLVERR);
    wr(18'h0_0010, 32'h0000_00ff, 4'hf, r);
    chk_resp(r, `OVTT_RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      thr = (i == 0) ? 8'h02 : (i == 1) ? 8'hf4 :
        8'(2 + $urandom % 243);
      wr(ba(`OVTT_THRESH_IDX), {24'h0, thr}, 4'h1, r);
      chk_resp(r, `OVTT_RESP_OKAY);
      rd(ba(`OVTT_THRESH_IDX), d, r);
      chk_word(d, {24'h0, thr});
      rd(ba(`OVTT_THRESH_UV_IDX), d, r);
      chk_word(d, 32'(thr) * 32'h0000_0c35);
      ch1_set <= {1'b0, thr, 3'b111};
      repeat (DEB + 5) @(posedge aclk);
      rd(ba(`OVTT_STATUS_IDX), d, r);
      chk_word(d & 32'h0000_0007, 32'h0000_0000);
      rd(ba(`OVTT_READING_IDX), d, r);
      chk_word(d, {20'h0, ch1_set});
      ch1_set <= {1'b0, thr - 8'h01, 3'b000};
      repeat (DEB / 2) @(posedge aclk);
      ch1_set <= {1'b0, thr, 3'b000};
      repeat (3) @(posedge aclk);
      ch1_set <= {1'b0, thr - 8'h01, 3'b101};
      repeat (DEB / 2) @(posedge aclk);
      rd(ba(`OVTT_STATUS_IDX), d, r);
      chk_word(d & 32'h0000_0007, 32'h0000_0002);
      repeat (DEB) @(posedge aclk);
      chk_word({31'h0, flag}, 32'h0000_0001);
      ch1_set <= {1'b0, thr, 3'b000};
      repeat (5) @(posedge aclk);
      chk_word({31'h0, flag}, 32'h0000_0000);
    end
    wr(ba(`OVTT_THRESH_IDX), 32'h0000_0000, 4'he, r);
    chk_resp(r, `OVTT_RESP_OKAY);
    rd(ba(`OVTT_THRESH_IDX), d, r);
    chk_word(d, {24'h0, thr});
    for (i = 0; i < 8; i++) begin
      tr = (i == 0) ? 8'h7f : (i == 1) ? 8'hff : 8'($urandom);
      ch2_set <= (i < 2) ? 12'hfff : 12'($urandom);
      wr(ba(`OVTT_TRIM_IDX), {24'h0, tr}, 4'h1, r);
      rd(ba(`OVTT_TRIM_IDX), d, r);
      chk_word(d, {24'h0, tr});
      repeat (4) @(posedge aclk);
      chk_word({20'h0, trimmed}, {20'h0, exp_trim(ch2_set, tr)});
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(ba(`OVTT_THRESH_IDX), d, r);
    chk_word(d, 32'h0000_0000);
    rd(ba(`OVTT_TRIM_IDX), d, r);
    chk_word(d, 32'h0000_0000);
    chk_word({31'h0, flag}, 32'h0000_0000);
    end_sim();
  end
endmodule

bind ovtt_top ovtt_top_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
  ovtt_top_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready),
  .temp_sense_channel_one(temp_sense_channel_one),
  .overtemp_one_fault_flag(overtemp_one_fault_flag));

//--- rtl/ovtt_consts.svh
// Function
// [R1] Trim bit 7 selects negative gain correction.
// [R2] Trim bits 6..0 scale channel two gain.
// [R3] Threshold gets a zero MSB, nine bits.
// [R4] Compare against channel one reading's nine MSBs.
// [R5] Hit when threshold strictly exceeds reading.
// [R6] Fault flag debounced over 100 ms.
// [R7] Threshold code is linear, 3.125 mV per step.
// [R8] Software programs threshold codes 2 to 244.
// [R9] Debounce restarts whenever the hit condition drops.
`ifndef OVTT_CONSTS_SVH
`define OVTT_CONSTS_SVH

// Bus geometry.
`define OVTT_ADDR_W 18
`define OVTT_DATA_W 32
`define OVTT_IDX_W 16
`define OVTT_IDX_LSB 2

// Register indices; the byte address is four times the index.
`define OVTT_TRIM_IDX 16'hfe74
`define OVTT_THRESH_IDX 16'hfe75
`define OVTT_READING_IDX 16'hfed7
`define OVTT_STATUS_IDX 16'hfe80
`define OVTT_THRESH_UV_IDX 16'hfe81

// Reset values.
`define OVTT_TRIM_RESET 8'h00
`define OVTT_THRESH_RESET 8'h00

// Field positions.
`define OVTT_TRIM_POL_BIT 7
`define OVTT_TRIM_MAG_MSB 6
`define OVTT_STAT_FLAG_BIT 0
`define OVTT_STAT_HIT_BIT 1
`define OVTT_STAT_RANGE_BIT 2

// Sensor reading geometry.
`define OVTT_READING_W 12
`define OVTT_CMP_W 9
`define OVTT_CMP_LSB 3
`define OVTT_TRIM_SHIFT 10

// Threshold scale and legal range.
`define OVTT_UV_PER_CODE 20'h0_0c35
`define OVTT_UV_W 20
`define OVTT_THRESH_MIN 8'h02
`define OVTT_THRESH_MAX 8'hf4

// Timing.
`define OVTT_CLK_MHZ 250
`define OVTT_DEBOUNCE_MS 100
`define OVTT_DEBOUNCE_CYCLES (`OVTT_DEBOUNCE_MS * `OVTT_CLK_MHZ * 1000)

// Bus responses.
`define OVTT_RESP_OKAY 2'b00
`define OVTT_RESP_SLVERR 2'b10

`endif

//--- rtl/ovtt_debounce.sv
`timescale 1ns/10ps
`include "ovtt_consts.svh"

module ovtt_debounce
  import ovtt_pkg::*;
#(
  parameter int unsigned CYCLES = `OVTT_DEBOUNCE_CYCLES
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Raw condition and debounced flag.
  input wire logic cond,
  output logic flag
);

  ovtt_deb_state_type s_reg;
  ovtt_deb_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (!cond) begin
      s_next.count = '0; // [R9]
      s_next.flag = 1'b0;
    end else if (s_reg.count >= 32'(CYCLES - 1)) begin
      s_next.flag = 1'b1; // [R6]
    end else begin
      s_next.count = s_reg.count + 32'h0000_0001; // [R9]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flag = s_reg.flag;

endmodule

//--- rtl/ovtt_gain_trim.sv
`timescale 1ns/10ps
`include "ovtt_consts.svh"

module ovtt_gain_trim
  import ovtt_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Trim setting and raw reading.
  input wire logic [7:0] trim,
  input wire logic [`OVTT_READING_W-1:0] raw,
  // Corrected reading.
  output logic [`OVTT_READING_W-1:0] trimmed
);

  localparam int PW = `OVTT_READING_W + `OVTT_TRIM_MAG_MSB + 1;
  localparam logic [PW:0] MAXV = (PW+1)'((1 << `OVTT_READING_W) - 1);

  ovtt_trim_state_type s_reg;
  ovtt_trim_state_type s_next;
  logic [PW-1:0] prod;
  logic [PW:0] delta;
  logic [PW:0] sum;

  always_comb begin
    s_next = s_reg;
    prod = PW'(raw) * PW'(trim[`OVTT_TRIM_MAG_MSB:0]); // [R2]
    delta = (PW+1)'(prod >> `OVTT_TRIM_SHIFT);
    if (trim[`OVTT_TRIM_POL_BIT]) begin // [R1]
      if (delta > (PW+1)'(raw)) begin
        sum = '0;
      end else begin
        sum = (PW+1)'(raw) - delta;
      end
    end else begin
      sum = (PW+1)'(raw) + delta;
    end
    if (sum > MAXV) begin
      s_next.trimmed = MAXV[`OVTT_READING_W-1:0];
    end else begin
      s_next.trimmed = sum[`OVTT_READING_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign trimmed = s_reg.trimmed;

endmodule

//--- rtl/ovtt_pkg.sv
`include "ovtt_consts.svh"

package ovtt_pkg;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [`OVTT_IDX_W-1:0] aw_idx;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`OVTT_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] trim;
    logic [7:0] thresh;
    logic [`OVTT_READING_W-1:0] reading;
    logic hit;
    logic [`OVTT_UV_W-1:0] thresh_uv;
  } ovtt_top_state_type;

  typedef struct packed {
    logic [31:0] count;
    logic flag;
  } ovtt_deb_state_type;

  typedef struct packed {
    logic [`OVTT_READING_W-1:0] trimmed;
  } ovtt_trim_state_type;

endpackage

//--- rtl/ovtt_top.sv
`timescale 1ns/10ps
`include "ovtt_consts.svh"

module ovtt_top
  import ovtt_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = `OVTT_DEBOUNCE_CYCLES
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,

  // Write address channel.
  input wire logic awvalid,
  output logic awready,
  input wire logic [`OVTT_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,

  // Write data channel.
  input wire logic wvalid,
  output logic wready,
  input wire logic [`OVTT_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,

  // Write response channel.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,

  // Read address channel.
  input wire logic arvalid,
  output logic arready,
  input wire logic [`OVTT_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,

  // Read data channel.
  output logic rvalid,
  input wire logic rready,
  output logic [`OVTT_DATA_W-1:0] rdata,
  output logic [1:0] rresp,

  // Sensor readings from the converter.
  input wire logic [`OVTT_READING_W-1:0] temp_sense_channel_one,
  input wire logic [`OVTT_READING_W-1:0] temp_sense_channel_two,

  // Results.
  output logic [`OVTT_READING_W-1:0] temp_sense_two_trimmed,
  output logic overtemp_one_fault_flag
);

  ////////////////////////////////////////////////////////////////////////////

  ovtt_top_state_type s_reg;
  ovtt_top_state_type s_next;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic have_aw;
  logic have_w;
  logic [`OVTT_IDX_W-1:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_en;
  logic [`OVTT_IDX_W-1:0] rd_idx;
  logic [`OVTT_CMP_W-1:0] thresh9;
  logic [`OVTT_CMP_W-1:0] reading9;
  logic range_bad;
  logic deb_flag;
  logic [`OVTT_READING_W-1:0] trim_out;

  // Address to register index.
  function automatic logic [`OVTT_IDX_W-1:0] to_idx(
    input logic [`OVTT_ADDR_W-1:0] addr
  );
    to_idx = addr[`OVTT_ADDR_W-1:`OVTT_IDX_LSB];
  endfunction

  // Known register test.
  function automatic logic is_mapped(input logic [`OVTT_IDX_W-1:0] idx);
    is_mapped = (idx == `OVTT_TRIM_IDX) || (idx == `OVTT_THRESH_IDX) ||
      (idx == `OVTT_READING_IDX) || (idx == `OVTT_STATUS_IDX) ||
      (idx == `OVTT_THRESH_UV_IDX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Handshakes.
  assign aw_fire = awvalid && s_reg.awready;
  assign w_fire = wvalid && s_reg.wready;
  assign ar_fire = arvalid && s_reg.arready;

  // Write address and data, either held or arriving now.
  assign have_aw = s_reg.aw_got || aw_fire;
  assign have_w = s_reg.w_got || w_fire;
  assign wr_idx = s_reg.aw_got ? s_reg.aw_idx : to_idx(awaddr);
  assign wr_byte = s_reg.w_got ? s_reg.wdata : wdata[7:0];
  assign wr_en = have_aw && have_w && !s_reg.bvalid;

  assign rd_idx = to_idx(araddr);

  ////////////////////////////////////////////////////////////////////////////

  // Threshold and comparison.
  assign thresh9 = {1'b0, s_reg.thresh}; // [R3]
  assign reading9 =
    s_reg.reading[`OVTT_READING_W-1:`OVTT_CMP_LSB]; // [R4]
  assign range_bad = (s_reg.thresh < `OVTT_THRESH_MIN) ||
    (s_reg.thresh > `OVTT_THRESH_MAX); // [R8]

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_next = s_reg;

    // Sample the channel one reading and form the comparison.
    s_next.reading = temp_sense_channel_one; // [R4]
    s_next.hit = thresh9 > reading9; // [R5]
    s_next.thresh_uv =
      `OVTT_UV_W'(s_reg.thresh) * `OVTT_UV_PER_CODE; // [R7]

    // Write address capture.
    if (aw_fire && !wr_en) begin
      s_next.aw_got = 1'b1;
      s_next.aw_idx = to_idx(awaddr);
    end

    // Write data capture.
    if (w_fire && !wr_en) begin
      s_next.w_got = 1'b1;
      s_next.wdata = wdata[7:0];
      s_next.wstrb0 = wstrb[0];
    end

    // Register write and response.
    if (wr_en) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = is_mapped(wr_idx) ? `OVTT_RESP_OKAY :
        `OVTT_RESP_SLVERR;
      if (s_reg.w_got ? s_reg.wstrb0 : wstrb[0]) begin
        if (wr_idx == `OVTT_TRIM_IDX) begin
          s_next.trim = wr_byte; // [R1] [R2]
        end
        if (wr_idx == `OVTT_THRESH_IDX) begin
          s_next.thresh = wr_byte; // [R3]
        end
      end
    end else if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
      s_next.bresp = `OVTT_RESP_OKAY;
    end

    // Ready toward the master.
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready = !s_next.w_got && !s_next.bvalid;

    // Read.
    if (ar_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `OVTT_RESP_OKAY;
      s_next.rdata = '0;
      case (rd_idx)
        `OVTT_TRIM_IDX: begin
          s_next.rdata[7:0] = s_reg.trim;
        end
        `OVTT_THRESH_IDX: begin
          s_next.rdata[7:0] = s_reg.thresh;
        end
        `OVTT_READING_IDX: begin
          s_next.rdata[`OVTT_READING_W-1:0] = s_reg.reading;
        end
        `OVTT_STATUS_IDX: begin
          s_next.rdata[`OVTT_STAT_FLAG_BIT] = deb_flag;
          s_next.rdata[`OVTT_STAT_HIT_BIT] = s_reg.hit;
          s_next.rdata[`OVTT_STAT_RANGE_BIT] = range_bad;
        end
        `OVTT_THRESH_UV_IDX: begin
          s_next.rdata[`OVTT_UV_W-1:0] = s_reg.thresh_uv;
        end
        default: begin
          s_next.rresp = `OVTT_RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.rdata = '0;
      s_next.rresp = `OVTT_RESP_OKAY;
    end
    s_next.arready = !s_next.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.trim <= `OVTT_TRIM_RESET;
      s_reg.thresh <= `OVTT_THRESH_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Debounce of the comparison result.
  ovtt_debounce #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .cond(s_reg.hit), // [R6] [R9]
    .flag(deb_flag)
  );

  // Gain correction of channel two.
  ovtt_gain_trim u_trim (
    .aclk(aclk),
    .aresetn(aresetn),
    .trim(s_reg.trim), // [R1] [R2]
    .raw(temp_sense_channel_two),
    .trimmed(trim_out)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Outputs.
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign temp_sense_two_trimmed = trim_out;
  assign overtemp_one_fault_flag = deb_flag;

endmodule
